/* usbirq_pkg.sv */
// Constants for the USB device interrupt enable and gating block
package usbirq_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [7:0]  IE0_OFS      = 8'h10;
   localparam logic [7:0]  CTRL_OFS     = 8'h20;
   localparam logic [7:0]  STAT_OFS     = 8'h24;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt enable register fields
   localparam logic [15:0] IE0_RESET    = 16'h0000;
   localparam int          SRC_LSB      = 8;
   localparam int          BUS_PWR_BIT  = 15;
   localparam int          WAKEUP_BIT   = 14;
   localparam int          STATE_LSB    = 4;
   localparam int          STAGE_LSB    = 0;
   localparam logic [15:0] ALWAYS_RW    = 16'hc000;

   ////////////////////////////////////////////////////////////////////////
   // Output control register fields
   localparam int          SENSE_BIT    = 1;
   localparam int          POL_BIT      = 0;
   localparam logic [1:0]  CTRL_RESET   = 2'h0;

   ////////////////////////////////////////////////////////////////////////
   // Status register fields
   localparam int          PEND_LSB     = 0;
   localparam int          PIN_BIT      = 8;
   localparam int          NEG_BIT      = 9;
   localparam int          REQ_BIT      = 10;

   ////////////////////////////////////////////////////////////////////////
   // Edge mode negate window: 32 cycles of 48 MHz, least time, rounded up
   localparam int          NEG_LINK_CYC = 32;
   localparam int          LINK_MHZ     = 48;
   localparam int          CLK_MHZ      = 100;
   localparam int          NEG_CYCLES   =
      (NEG_LINK_CYC * CLK_MHZ + LINK_MHZ - 1) / LINK_MHZ;

endpackage

/* usbirq_pin_drive.sv */
// Interrupt pin driver with edge mode negate window and polarity select
`timescale 1ns/1ps

module usbirq_pin_drive #(
   parameter int NEG_CYC = usbirq_pkg::NEG_CYCLES
) (
   // Clock, reset, enable
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   // Request and clear event
   input  wire logic irqReq,
   input  wire logic clearEvt,
   input  wire logic clkOn,
   // Output mode
   input  wire logic levelSense,
   input  wire logic activeHigh,
   // Pin and state
   output logic      irqPin,
   output logic      negating
);

   localparam int CW = $clog2(NEG_CYC + 1);

   logic [CW-1:0] negCnt_r;
   logic          asserted;

   ////////////////////////////////////////////////////////////////////////
   // Negate window, skipped while the controller clock is stopped
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         negCnt_r <= '0;
      end else if (ce) begin
         if (!levelSense && clkOn && clearEvt && irqReq) begin
            negCnt_r <= CW'(NEG_CYC);
         end else if (negCnt_r != '0) begin
            negCnt_r <= negCnt_r - CW'(1);
         end
      end
   end

   assign negating = (negCnt_r != '0);
   // Level mode holds while any source stays pending
   assign asserted = irqReq && !(negating && !levelSense);

   ////////////////////////////////////////////////////////////////////////
   // Registered pin, idles at the negated level
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqPin <= 1'b1;
      end else if (ce) begin
         irqPin <= activeHigh ? asserted : !asserted;
      end
   end

endmodule // usbirq_pin_drive

/* usbirq_enable_mask.sv */
// USB device interrupt enable register, flag gating and request output
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

// Functional notes
// - 16-bit enable register at 0x10, read/write, cleared by both resets.
// - Bit 15 passes the bus power flag to the interrupt.
// - Bus power and wakeup enables stay writable with controller clock off.
// - Bit 14 passes the wakeup detect flag to the interrupt.
// - Bit 13 passes the frame start flag to the interrupt.
// - Bit 12 passes the device state change flag to the interrupt.
// - Bit 11 passes the control stage change flag to the interrupt.
// - Bit 10 passes the buffer drained or size error flag.
// - Bit 9 passes the buffer not ready flag to the interrupt.
// - Bit 8 passes the buffer ready flag to the interrupt.
// - Bit 7 lets bus reset set the device state flag.
// - Bit 6 lets set address set the device state flag.
// - Bit 5 lets set configuration set the device state flag.
// - Bit 4 lets suspend set the device state flag.
// - Bit 3 lets write status stage entry set the control stage flag.
// - Bit 2 lets read status stage entry set the control stage flag.
// - Bit 1 lets status stage completion set the control stage flag.
// - Bit 0 lets a sequence fault set the control stage flag.
// - Setup stage completion always sets the control stage flag.
// - Edge mode clear with others pending negates for 32 slow cycles, only with controller clock on.
// - Polarity bit zero is active low, one is active high.
module usbirq_enable_mask #(
   parameter int ADDR_W  = 8,
   parameter int NEG_CYC = usbirq_pkg::NEG_CYCLES
) (
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              ce,
   // Wishbone slave
   input  wire logic [ADDR_W-1:0] wbAdr,
   input  wire logic [31:0]       wbDatI,
   output logic      [31:0]       wbDatO,
   input  wire logic              wbWe,
   input  wire logic [3:0]        wbSel,
   input  wire logic              wbCyc,
   input  wire logic              wbStb,
   output logic                   wbAck,
   // Controller state
   input  wire logic              softReset,
   input  wire logic              internalClockOn,
   // Source flags, bit i pairs with enable bit 8+i
   input  wire logic [7:0]        srcFlags,
   input  wire logic              flagCleared,
   // Device state events: suspend, set config, set address, bus reset
   input  wire logic [3:0]        stateEvt,
   // Stage events: fault, done, read status, write status
   input  wire logic [3:0]        stageEvt,
   input  wire logic              setupDoneEvt,
   // Gated flag set strobes
   output logic                   deviceStateSet,
   output logic                   controlStageSet,
   // Interrupt
   output logic                   irqRequest,
   output logic                   irqPin,
   output logic      [15:0]       enableBits
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [15:0] ie_r;
   logic [1:0]  ctrl_r;
   logic        ack_r;
   logic [31:0] rdat_r;
   logic        dss_r;
   logic        css_r;
   logic        req_r;
   logic [7:0]  pend;
   logic        reqNxt;
   logic        access;
   logic        wrLo;
   logic        wrHi;
   logic [15:0] wrMask;
   logic [15:0] ieNxt;
   logic [31:0] rdNxt;
   logic        pinInt;
   logic        negating;
   logic [3:0]  stateHit;
   logic [3:0]  stageHit;

   ////////////////////////////////////////////////////////////////////////
   // Bus access decode
   assign access = wbCyc && wbStb && !ack_r;
   assign wrLo   = access && wbWe && wbSel[0];
   assign wrHi   = access && wbWe && wbSel[1];

   always_comb begin
      wrMask = 16'h0000;
      if (wrLo) begin
         wrMask[7:0] = 8'hff;
      end
      if (wrHi) begin
         wrMask[15:8] = 8'hff;
      end
      if (!internalClockOn) begin
         wrMask = wrMask & usbirq_pkg::ALWAYS_RW;
      end
   end

   assign ieNxt = (ie_r & ~wrMask) | (wbDatI[15:0] & wrMask);

   ////////////////////////////////////////////////////////////////////////
   // Enable register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ie_r <= usbirq_pkg::IE0_RESET;
      end else if (ce) begin
         if (softReset) begin
            ie_r <= usbirq_pkg::IE0_RESET;
         end else if (wbAdr == ADDR_W'(usbirq_pkg::IE0_OFS)) begin
            ie_r <= ieNxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output mode register, holds sense and polarity
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_r <= usbirq_pkg::CTRL_RESET;
      end else if (ce) begin
         if (softReset) begin
            ctrl_r <= usbirq_pkg::CTRL_RESET;
         end else if (wrLo && wbAdr == ADDR_W'(usbirq_pkg::CTRL_OFS)) begin
            ctrl_r <= wbDatI[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-source gating
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_src
         assign pend[gi] = srcFlags[gi] && ie_r[usbirq_pkg::SRC_LSB + gi];
      end
   endgenerate

   assign reqNxt = |pend;

   ////////////////////////////////////////////////////////////////////////
   // Event gating toward the flag register
   generate
      for (gi = 0; gi < 4; gi++) begin : g_evt
         assign stateHit[gi] =
            stateEvt[gi] && ie_r[usbirq_pkg::STATE_LSB + gi];
         assign stageHit[gi] =
            stageEvt[gi] && ie_r[usbirq_pkg::STAGE_LSB + gi];
      end
   endgenerate

   // Strobes are registered, so the flag sets one cycle after the event
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dss_r <= 1'b0;
         css_r <= 1'b0;
      end else if (ce) begin
         dss_r <= |stateHit;
         css_r <= (|stageHit) || setupDoneEvt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered request level
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         req_r <= 1'b0;
      end else if (ce) begin
         req_r <= reqNxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin driver
   usbirq_pin_drive #(
      .NEG_CYC    (NEG_CYC)
   ) u_pin (
      .clk        (clk),
      .rst_b      (rst_b),
      .ce         (ce),
      .irqReq     (reqNxt),
      .clearEvt   (flagCleared),
      .clkOn      (internalClockOn),
      .levelSense (ctrl_r[usbirq_pkg::SENSE_BIT]),
      .activeHigh (ctrl_r[usbirq_pkg::POL_BIT]),
      .irqPin     (pinInt),
      .negating   (negating)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read mux, unmapped reads return zero
   always_comb begin
      rdNxt = 32'h0000_0000;
      if (wbAdr == ADDR_W'(usbirq_pkg::IE0_OFS)) begin
         rdNxt[15:0] = ie_r;
      end else if (wbAdr == ADDR_W'(usbirq_pkg::CTRL_OFS)) begin
         rdNxt[1:0] = ctrl_r;
      end else if (wbAdr == ADDR_W'(usbirq_pkg::STAT_OFS)) begin
         rdNxt[usbirq_pkg::PEND_LSB +: 8] = pend;
         rdNxt[usbirq_pkg::PIN_BIT]       = pinInt;
         rdNxt[usbirq_pkg::NEG_BIT]       = negating;
         rdNxt[usbirq_pkg::REQ_BIT]       = req_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone answer: ack one cycle after the request, every address
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else if (ce) begin
         ack_r <= access;
         if (access && !wbWe) begin
            rdat_r <= rdNxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wbAck           = ack_r;
   assign wbDatO          = rdat_r;
   assign deviceStateSet  = dss_r;
   assign controlStageSet = css_r;
   assign irqRequest      = req_r;
   assign irqPin          = pinInt;
   assign enableBits      = ie_r;

endmodule // usbirq_enable_mask

/* usbirq_checker_sva.sv */
// Port assertions for the USB interrupt enable and gating block
`timescale 1ns/1ps
module usbirq_checker #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic              ce,
   // Register bus
   input wire logic [ADDR_W-1:0] wbAdr,
   input wire logic [31:0]       wbDatI,
   input wire logic              wbWe,
   input wire logic [3:0]        wbSel,
   input wire logic              wbCyc,
   input wire logic              wbStb,
   input wire logic              wbAck,
   // Controller state and events
   input wire logic              softReset,
   input wire logic              internalClockOn,
   input wire logic [7:0]        srcFlags,
   input wire logic [3:0]        stateEvt,
   input wire logic [3:0]        stageEvt,
   input wire logic              setupDoneEvt,
   // Outputs
   input wire logic              deviceStateSet,
   input wire logic              controlStageSet,
   input wire logic              irqRequest,
   input wire logic [15:0]       enableBits
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic take;
   logic ieWr;
   assign take = wbCyc && wbStb && !wbAck && ce;
   assign ieWr = take && wbWe && wbAdr == usbirq_pkg::IE0_OFS
                 && wbSel[1:0] == 2'h3 && !softReset;
   ack_after_take_a:
      assert property (take |=> wbAck) else $error("no ack after request");
   ack_one_cycle_a:
      assert property (wbAck |=> !wbAck) else $error("ack held too long");
   enable_write_a:
      assert property (ieWr && internalClockOn |=>
         enableBits == $past(wbDatI[15:0])) else $error("enable write lost");
   clock_off_write_a:
      assert property (ieWr && !internalClockOn |=> enableBits ==
         {$past(wbDatI[15:14]), $past(enableBits[13:0])})
         else $error("clock off write wrong");
   soft_clear_a:
      assert property (softReset && ce |=> enableBits == 16'h0000)
         else $error("soft reset did not clear");
   request_or_a:
      assert property ($past(rst_b) && $past(ce) |-> irqRequest ==
         |($past(srcFlags) & $past(enableBits[15:8])))
         else $error("request not flag and enable");
   state_gate_a:
      assert property ($past(rst_b) && $past(ce) |-> deviceStateSet ==
         |($past(stateEvt) & $past(enableBits[7:4])))
         else $error("state strobe gating wrong");
   stage_gate_a:
      assert property ($past(rst_b) && $past(ce) |-> controlStageSet ==
         (|($past(stageEvt) & $past(enableBits[3:0])) || $past(setupDoneEvt)))
         else $error("stage strobe gating wrong");
   cover property (ieWr && !internalClockOn);
   cover property (deviceStateSet);
   cover property (controlStageSet && irqRequest);
endmodule // usbirq_checker

bind usbirq_enable_mask usbirq_checker #(.ADDR_W(ADDR_W)) i_usbirq_checker (.*);

/* usbirq_host.sv */
// Host processor model driving classic Wishbone register cycles
`timescale 1ns/1ps
module usbirq_host (
   // Clock
   input  wire logic        clk,
   // Wishbone master
   output logic [7:0]       wbAdr,
   output logic [31:0]      wbDatI,
   output logic             wbWe,
   output logic [3:0]       wbSel,
   output logic             wbCyc,
   output logic             wbStb,
   input  wire logic        wbAck,
   input  wire logic [31:0] wbDatO
);
   initial begin
      {wbAdr, wbDatI, wbWe, wbSel, wbCyc, wbStb} = '0;
   end
   // Waits on ack without limit; the bench watchdog ends a hang
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatI} <= {2'h3, we, 4'hf, a, d};
      do @(posedge clk); while (wbAck !== 1'b1);
      q = wbDatO;
      // Released data lines show a changed value, not the old one
      {wbCyc, wbStb, wbWe, wbDatI} <= {3'h0, ~d};
   endtask
endmodule // usbirq_host

/* tb_usb_device_irq_enable_mask.sv */
// Self-checking bench for the USB interrupt enable and gating block
`timescale 1ns/1ps
module tb_usb_device_irq_enable_mask;
   localparam int NEG = 4;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic        softReset = 1'b0;
   logic        internalClockOn = 1'b1;
   logic        flagCleared = 1'b0;
   logic        setupDoneEvt = 1'b0;
   logic [7:0]  srcFlags = '0;
   logic [3:0]  stateEvt = '0;
   logic [3:0]  stageEvt = '0;
   logic [7:0]  wbAdr;
   logic [31:0] wbDatI, wbDatO, q, rnd = 32'h9553a939;
   logic [3:0]  wbSel;
   logic        wbWe, wbCyc, wbStb, wbAck, irqRequest, irqPin;
   logic        deviceStateSet, controlStageSet;
   logic [15:0] enableBits, enM = '0;
   int          miscompares = 0, comparisons = 0, cnt;
   always #5 clk = ~clk;
   usbirq_host i_usbirq_host (.*);
   usbirq_enable_mask #(.NEG_CYC(NEG)) i_usbirq_enable_mask (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("Mismatches %0d, comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_usbirq_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      i_usbirq_host.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   initial begin
      tick(4);
      rst_b <= 1'b1;
      rd(8'h10);
      chkVal(q, 32'h0);
      wr(8'h30, 32'hffff);
      rd(8'h30);
      chkVal(q, 32'h0);
      for (int n = 0; n < 12; n++) begin
         rnd = lfsr(rnd);
         internalClockOn <= rnd[31];
         enM = rnd[31] ? rnd[15:0] : {rnd[15:14], enM[13:0]};
         wr(8'h10, rnd);
         rd(8'h10);
         chkVal(q, {16'h0, enM});
         chkVal({16'h0, enableBits}, {16'h0, enM});
      end
      internalClockOn <= 1'b1;
      wr(8'h10, 32'hffff);
      softReset <= 1'b1;
      tick(1);
      softReset <= 1'b0;
      rd(8'h10);
      chkVal(q, 32'h0);
      for (int n = 0; n < 40; n++) begin
         rnd = lfsr(rnd);
         enM = rnd[15:0];
         wr(8'h10, rnd);
         repeat (4) begin
            rnd = lfsr(rnd);
            {setupDoneEvt, stageEvt, stateEvt, srcFlags} <= rnd[16:0];
            tick(1);
            {stateEvt, stageEvt, setupDoneEvt} <= '0;
            tick(1);
            chkVal(32'(irqRequest), 32'(|(rnd[7:0] & enM[15:8])));
            chkVal(32'(deviceStateSet), 32'(|(rnd[11:8] & enM[7:4])));
            chkVal(32'(controlStageSet),
                   32'(|(rnd[15:12] & enM[3:0]) | rnd[16]));
         end
      end
      wr(8'h10, 32'hff00);
      for (int p = 0; p < 2; p++) begin
         wr(8'h20, 32'(2 + p));
         srcFlags <= 8'h10;
         tick(2);
         chkVal(32'(irqPin), 32'(p));
         srcFlags <= 8'h00;
         tick(2);
         chkVal(32'(irqPin), 32'(1 - p));
      end
      wr(8'h20, 32'h0);
      for (int c = 0; c < 2; c++) begin
         internalClockOn <= c[0];
         srcFlags <= 8'h03;
         tick(3);
         chkVal(32'(irqPin), 32'h0);
         srcFlags <= 8'h02;
         flagCleared <= 1'b1;
         tick(1);
         flagCleared <= 1'b0;
         cnt = 0;
         repeat (12) begin
            tick(1);
            cnt += irqPin;
         end
         chkVal(32'(cnt), c ? 32'(NEG) : 32'h0);
         chkVal(32'(irqPin), 32'h0);
      end
      // Clock enable low must freeze the request level
      srcFlags <= 8'h00;
      tick(2);
      ce <= 1'b0;
      srcFlags <= 8'h01;
      tick(3);
      chkVal(32'(irqRequest), 32'h0);
      ce <= 1'b1;
      tick(2);
      chkVal(32'(irqRequest), 32'h1);
      stop_test();
   end
   // The sequence needs under 2000 cycles
   initial begin
      tick(5000);
      miscompares++;
      stop_test();
   end
endmodule // tb_usb_device_irq_enable_mask
